// file: hw/clk_pm_pkg.sv
// Shared constants and types of the system clock and power manager
package clk_pm_pkg;

  // ---------------------------------------------------------------
  // Clock sources
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_RING = 3'h0,
    SRC_HF_XTAL = 3'h1,
    SRC_HF_EXT = 3'h2,
    SRC_LF_XTAL = 3'h3,
    SRC_LF_EXT = 3'h4
  } clk_src_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_STOP = 2'h1,
    ST_WARM = 2'h2
  } pm_state_type;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STOP_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Control register fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_CD_LSB = 3;
  localparam int CTRL_PME_BIT = 5;
  localparam int CTRL_SWB_BIT = 6;
  localparam int CTRL_FAST_WAKE_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Stop register fields
  localparam int STOP_REQ_BIT = 0;

  // Status register fields
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_READY_BIT = 3;
  localparam int STAT_STOP_BIT = 4;
  localparam int STAT_DIV256_BIT = 5;
  localparam int STAT_SLOW_BIT = 6;
  localparam int STAT_WARM_BIT = 7;

  // ---------------------------------------------------------------
  // Divide ratios and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] CD_DIV256 = 2'h0;
  localparam logic [1:0] CD_SLOW = 2'h3;
  localparam int RATIO_W = 9;
  localparam logic [8:0] RATIO_DIV256 = 9'h100;
  localparam logic [8:0] RATIO_ONE = 9'h001;
  localparam int WARMUP_OSC = 65536;

endpackage : clk_pm_pkg

// file: hw/osc_warmup.sv
// Crystal warmup counter: counts oscillations after each restart
module osc_warmup
  import clk_pm_pkg::*;
#(
  parameter int WARM_COUNT = WARMUP_OSC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic osc_tick_i,
  output logic ready_o
);

  localparam int CW = $clog2(WARM_COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(WARM_COUNT - 1);

  if (WARM_COUNT < 1) begin : g_bad_count
    $error("osc_warmup: WARM_COUNT must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ready;
  } warm_state_type;

  warm_state_type s_r;
  warm_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (restart_i) begin
      s_nxt.cnt = '0;
      s_nxt.ready = 1'b0;
    end else if (osc_tick_i && !s_r.ready) begin
      s_nxt.cnt = s_r.cnt + CW'(1);
      s_nxt.ready = (s_r.cnt == LAST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ready_o = s_r.ready;

endmodule : osc_warmup

// file: hw/tick_divider.sv
// Oscillator tick divider; ratio is taken only at a system tick boundary
module tick_divider
  import clk_pm_pkg::*;
#(
  parameter int W = RATIO_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_tick_i,
  input wire logic [W-1:0] ratio_i,
  output logic boundary_o,
  output logic sys_tick_o
);

  if (W < 9) begin : g_bad_width
    $error("tick_divider: W must hold a ratio of 256");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] ratio;
    logic tick;
  } div_state_type;

  div_state_type s_r;
  div_state_type s_nxt;

  // Last oscillator tick of the current system cycle
  assign boundary_o = osc_tick_i && (s_r.cnt + W'(1) >= s_r.ratio);

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (boundary_o) begin
      // New ratio only here, so no system cycle is ever cut short
      s_nxt.cnt = '0;
      s_nxt.ratio = (ratio_i == '0) ? W'(1) : ratio_i;
      s_nxt.tick = 1'b1;
    end else if (osc_tick_i) begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{cnt: '0, ratio: W'(1), tick: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sys_tick_o = s_r.tick;

endmodule : tick_divider

// file: hw/sys_clock_pm.sv
// System clock source selection, divider and power-mode manager
//
// Notes on behaviour
// - System clock comes from ring, HF crystal, HF external, 32k crystal or 32k external.
// - Every crystal restart, including after stop, counts 65536 oscillations before use.
// - During warmup the ring oscillator clocks the system; crystal taken once ready.
// - Software divider gives a system cycle of 1, 2, 4 or 8 oscillator cycles.
// - Divide-by-256 mode when power-management enable is 1 and divide field is 00b.
// - In divide-by-256 mode each system cycle lasts 256 oscillator cycles.
// - Slow mode when enable is 1 and divide field is 11b; uses 32kHz oscillator.
// - Writing 1 to the stop-request bit enters stop mode.
// - With switchback on, an enabled interrupt leaves either power mode for faster clock.
// - In stop the external oscillator and system clock halt; processing stops.
// - Stop ends on external interrupt, reset pin assertion or time-of-day alarm.
// - On stop exit, option selects waiting for warmup or running from ring at once.
// - After power-on reset the ring oscillator is the system clock source.
// - During reset both HF and ring oscillators keep running while code is held.
//
// Chosen here: register access over Wishbone and the address map.
module sys_clock_pm
  import clk_pm_pkg::*;
#(
  parameter int WARM_COUNT = WARMUP_OSC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator ticks, one cycle pulse per oscillation
  input wire logic ring_tick_i,
  input wire logic hf_xtal_tick_i,
  input wire logic hf_ext_tick_i,
  input wire logic lf_xtal_tick_i,
  input wire logic lf_ext_tick_i,
  // Wake and switchback sources
  input wire logic ext_int_wake_i,
  input wire logic ext_reset_n_i,
  input wire logic rtc_alarm_i,
  input wire logic irq_pending_i,
  // Oscillator control and system clock
  output logic ring_osc_en_o,
  output logic hf_osc_en_o,
  output logic sys_tick_o,
  output logic core_hold_o,
  output logic stopped_o
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // A zero count would call the crystal ready before it has settled
  if (WARM_COUNT < 1) begin : g_bad_warm_count
    $error("sys_clock_pm: WARM_COUNT must be at least 1");
  end
  // The divider must hold the divide-by-256 ratio
  if (RATIO_W < 9) begin : g_bad_ratio_width
    $error("sys_clock_pm: RATIO_W too narrow for divide-by-256");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] src_sel;
    logic [1:0] clock_divide_select;
    logic power_mgmt_enable;
    logic switchback_en;
    logic fast_wake;
    pm_state_type pm;
    clk_src_type active_src;
    logic hold;
    logic ack;
    logic [7:0] rdata;
  } pm_regs_type;

  pm_regs_type s_r;
  pm_regs_type s_nxt;

  logic xtal_ready;
  logic div_boundary;
  logic div_tick;
  logic src_tick;
  logic [RATIO_W-1:0] ratio;
  logic div256_power_mode;
  logic slow_osc_power_mode;
  logic wake_event;
  logic bus_req;
  logic bus_wr;
  logic [2:0] status_src;
  clk_src_type want_src;
  clk_src_type sel_src;
  logic ctrl_wr;
  logic stop_wr;
  logic rd_req;
  logic power_mode;
  logic switchback_hit;
  logic wait_for_xtal;
  logic [7:0] ctrl_rd;
  logic [7:0] stop_rd;
  logic [7:0] status_rd;

  // ---------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------
  // Mode changes reach the divider only at the next system cycle boundary
  assign div256_power_mode = s_r.power_mgmt_enable
                             && (s_r.clock_divide_select == CD_DIV256);
  assign slow_osc_power_mode = s_r.power_mgmt_enable
                               && (s_r.clock_divide_select == CD_SLOW);

  // Any of the three stop exit events
  assign wake_event = ext_int_wake_i || !ext_reset_n_i || rtc_alarm_i;

  // ---------------------------------------------------------------
  // Source choice
  // ---------------------------------------------------------------
  always_comb begin
    // Codes above the last source fall back to the ring oscillator
    case (s_r.src_sel)
      3'h1: sel_src = SRC_HF_XTAL;
      3'h2: sel_src = SRC_HF_EXT;
      3'h3: sel_src = SRC_LF_XTAL;
      3'h4: sel_src = SRC_LF_EXT;
      default: sel_src = SRC_RING;
    endcase
  end

  always_comb begin
    want_src = sel_src;
    if (slow_osc_power_mode) begin
      // Slow mode always runs from the 32kHz side
      want_src = (sel_src == SRC_LF_EXT) ? SRC_LF_EXT : SRC_LF_XTAL;
    end else if (sel_src == SRC_HF_XTAL && !xtal_ready) begin
      // Crystal not settled yet: borrow the ring oscillator
      want_src = SRC_RING;
    end
  end

  always_comb begin
    case (s_r.active_src)
      SRC_RING: src_tick = ring_tick_i;
      SRC_HF_XTAL: src_tick = hf_xtal_tick_i;
      SRC_HF_EXT: src_tick = hf_ext_tick_i;
      SRC_LF_XTAL: src_tick = lf_xtal_tick_i;
      SRC_LF_EXT: src_tick = lf_ext_tick_i;
      default: src_tick = ring_tick_i;
    endcase
  end

  // ---------------------------------------------------------------
  // Divide ratio
  // ---------------------------------------------------------------
  always_comb begin
    if (div256_power_mode) begin
      ratio = RATIO_DIV256;
    end else if (slow_osc_power_mode) begin
      // Slow mode runs the 32kHz source undivided
      ratio = RATIO_ONE;
    end else begin
      ratio = RATIO_ONE << s_r.clock_divide_select;
    end
  end

  // ---------------------------------------------------------------
  // Crystal warmup and divider
  // ---------------------------------------------------------------
  // Counter restarts whenever the crystal is halted, so every restart counts again
  osc_warmup #(
    .WARM_COUNT(WARM_COUNT)
  ) u_warmup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(s_r.pm == ST_STOP),
    .osc_tick_i(hf_xtal_tick_i),
    .ready_o(xtal_ready)
  );

  // No ticks reach the divider while stopped
  tick_divider #(
    .W(RATIO_W)
  ) u_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_tick_i(src_tick && (s_r.pm != ST_STOP)),
    .ratio_i(ratio),
    .boundary_o(div_boundary),
    .sys_tick_o(div_tick)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign status_src = s_r.active_src;
  assign ctrl_wr = bus_wr && (wb_adr_i == CTRL_OFS);
  assign stop_wr = bus_wr && (wb_adr_i == STOP_OFS) && wb_dat_i[STOP_REQ_BIT];
  assign rd_req = bus_req && !wb_we_i;

  // ---------------------------------------------------------------
  // Read views
  // ---------------------------------------------------------------
  assign ctrl_rd = {s_r.fast_wake,
                    s_r.switchback_en,
                    s_r.power_mgmt_enable,
                    s_r.clock_divide_select,
                    s_r.src_sel};
  assign stop_rd = {7'h00, s_r.pm == ST_STOP};
  // Status shows the source in use, which follows the selection at a boundary and is forced to the ring oscillator while stopped
  assign status_rd = {s_r.pm == ST_WARM,
                      slow_osc_power_mode,
                      div256_power_mode,
                      s_r.pm == ST_STOP,
                      xtal_ready,
                      status_src};

  // ---------------------------------------------------------------
  // Mode exits
  // ---------------------------------------------------------------
  assign power_mode = div256_power_mode || slow_osc_power_mode;
  // With switchback on, a pending interrupt in a power mode clears the enable, returning to the divide field ratio
  assign switchback_hit = s_r.switchback_en && irq_pending_i && power_mode;
  // Wake waits for the crystal only when it is the chosen clock
  assign wait_for_xtal = !s_r.fast_wake && (sel_src == SRC_HF_XTAL)
                         && !slow_osc_power_mode;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // One-cycle ack; a strobe held high is answered every second cycle
    s_nxt.ack = bus_req;
    s_nxt.hold = (s_r.pm != ST_RUN);

    // Register writes
    if (ctrl_wr) begin
      s_nxt.src_sel = wb_dat_i[CTRL_SRC_LSB +: 3];
      s_nxt.clock_divide_select = wb_dat_i[CTRL_CD_LSB +: 2];
      s_nxt.power_mgmt_enable = wb_dat_i[CTRL_PME_BIT];
      s_nxt.switchback_en = wb_dat_i[CTRL_SWB_BIT];
      s_nxt.fast_wake = wb_dat_i[CTRL_FAST_WAKE_BIT];
    end

    // Switchback; hardware clear wins over a write in the same cycle
    if (switchback_hit) begin
      s_nxt.power_mgmt_enable = 1'b0;
    end

    // Register reads
    s_nxt.rdata = 8'h00;
    if (rd_req) begin
      case (wb_adr_i)
        CTRL_OFS: begin
          s_nxt.rdata = ctrl_rd;
        end
        STOP_OFS: begin
          s_nxt.rdata = stop_rd;
        end
        STATUS_OFS: begin
          s_nxt.rdata = status_rd;
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Power state machine
    case (s_r.pm)
      ST_RUN: begin
        if (stop_wr) begin
          s_nxt.pm = ST_STOP;
        end
      end
      ST_STOP: begin
        if (wake_event) begin
          if (wait_for_xtal) begin
            s_nxt.pm = ST_WARM;
          end else begin
            s_nxt.pm = ST_RUN;
          end
        end
      end
      ST_WARM: begin
        if (xtal_ready) begin
          s_nxt.pm = ST_RUN;
        end
      end
      default: begin
        s_nxt.pm = ST_RUN;
      end
    endcase

    // Source switches only between system cycles
    if (div_boundary) begin
      s_nxt.active_src = want_src;
    end
    // While halted nothing ticks; fall back to the ring oscillator directly
    if (s_r.pm == ST_STOP) begin
      s_nxt.active_src = SRC_RING;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{src_sel: CTRL_RESET[CTRL_SRC_LSB +: 3],
               clock_divide_select: CTRL_RESET[CTRL_CD_LSB +: 2],
               power_mgmt_enable: CTRL_RESET[CTRL_PME_BIT],
               switchback_en: CTRL_RESET[CTRL_SWB_BIT],
               fast_wake: CTRL_RESET[CTRL_FAST_WAKE_BIT],
               pm: ST_RUN,
               active_src: SRC_RING,
               hold: 1'b1,
               ack: 1'b0,
               rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Both oscillators stay on through reset; only stop turns them off
  assign hf_osc_en_o = (s_r.pm != ST_STOP);
  assign ring_osc_en_o = (s_r.pm != ST_STOP);
  // Warm wait keeps the core held but lets the count go on
  assign sys_tick_o = div_tick && (s_r.pm == ST_RUN);
  assign core_hold_o = s_r.hold;
  assign stopped_o = (s_r.pm == ST_STOP);
  // Ack and read data leave straight from flops
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = {24'h00_0000, s_r.rdata};

endmodule : sys_clock_pm

// file: testbench/osc_model.sv
// Oscillator models feeding the clock manager with one-cycle tick pulses
module osc_model
#(
  parameter int PER [5] = '{2, 3, 4, 7, 9}
) (
  input wire logic clk_i,
  input wire logic ring_en_i,
  input wire logic hf_en_i,
  output logic [4:0] tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Tick generators
  // ---------------------------------------------------------------
  // External sources and the 32k crystal run free; ring and HF crystal only while enabled
  int cnt [5] = '{default: 0};
  logic [4:0] run;
  assign run = {3'h7, hf_en_i, ring_en_i};
  always @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) begin
      tick_o[i] <= run[i] && cnt[i] == PER[i] - 1;
      cnt[i] <= (!run[i] || cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
    end
  end
endmodule : osc_model

// file: testbench/clk_pm_monitor.sv
// Concurrent checks on the ports of the clock and power manager
module clk_pm_monitor
  import clk_pm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic ring_tick_i,
  input wire logic hf_xtal_tick_i,
  input wire logic hf_ext_tick_i,
  input wire logic lf_xtal_tick_i,
  input wire logic lf_ext_tick_i,
  input wire logic ext_int_wake_i,
  input wire logic ext_reset_n_i,
  input wire logic rtc_alarm_i,
  input wire logic ring_osc_en_o,
  input wire logic hf_osc_en_o,
  input wire logic sys_tick_o,
  input wire logic stopped_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic take;
  logic wake;
  logic any_tick;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wake = ext_int_wake_i || !ext_reset_n_i || rtc_alarm_i;
  assign any_tick = ring_tick_i | hf_xtal_tick_i | hf_ext_tick_i | lf_xtal_tick_i | lf_ext_tick_i;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("bus request not acknowledged one cycle later");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");
  a_stop_entry: assert property (take && wb_we_i && wb_adr_i == STOP_OFS && wb_sel_i[0]
    && wb_dat_i[STOP_REQ_BIT] && !wake |=> stopped_o)
    else $error("stop request did not stop the device");
  a_stop_no_tick: assert property (stopped_o |-> !sys_tick_o)
    else $error("system tick while stopped");
  a_stop_osc_off: assert property (stopped_o |-> !hf_osc_en_o && !ring_osc_en_o)
    else $error("oscillator left running while stopped");
  a_wake_exit: assert property (stopped_o && wake |=> !stopped_o)
    else $error("wake event did not end stop");
  a_reset_osc_run: assert property ($fell(rst_i) |-> ring_osc_en_o && hf_osc_en_o)
    else $error("oscillator halted during reset");
  a_tick_has_cause: assert property (sys_tick_o |-> $past(any_tick))
    else $error("system tick without a source tick");
  c_stop_wake: cover property (stopped_o ##1 !stopped_o);
  c_rtc_wake: cover property (stopped_o && rtc_alarm_i);
  c_bus_write: cover property (take && wb_we_i);
endmodule : clk_pm_monitor

bind sys_clock_pm clk_pm_monitor clk_pm_monitor_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .ring_tick_i(ring_tick_i), .hf_xtal_tick_i(hf_xtal_tick_i), .hf_ext_tick_i(hf_ext_tick_i),
  .lf_xtal_tick_i(lf_xtal_tick_i), .lf_ext_tick_i(lf_ext_tick_i),
  .ext_int_wake_i(ext_int_wake_i), .ext_reset_n_i(ext_reset_n_i), .rtc_alarm_i(rtc_alarm_i),
  .ring_osc_en_o(ring_osc_en_o), .hf_osc_en_o(hf_osc_en_o), .sys_tick_o(sys_tick_o),
  .stopped_o(stopped_o));

// file: testbench/tb_sys_clock_pm.sv
// Self-checking bench for the system clock and power manager
module tb_sys_clock_pm import clk_pm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WARM = 16;
  localparam int PER [5] = '{2, 3, 4, 7, 9};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dw = 32'h0;
  logic ext_int = 1'b0, ext_rst_n = 1'b1, rtc = 1'b0, irq = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ring_osc_en_o, hf_osc_en_o, sys_tick_o, core_hold_o, stopped_o;
  logic [4:0] tick;
  int n_errors = 0;
  int comparisons = 0;

  osc_model #(.PER(PER)) osc_model_i (.clk_i(clk_i), .ring_en_i(ring_osc_en_o),
    .hf_en_i(hf_osc_en_o), .tick_o(tick));

  sys_clock_pm #(.WARM_COUNT(WARM)) sys_clock_pm_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ring_tick_i(tick[0]),
    .hf_xtal_tick_i(tick[1]), .hf_ext_tick_i(tick[2]), .lf_xtal_tick_i(tick[3]),
    .lf_ext_tick_i(tick[4]), .ext_int_wake_i(ext_int), .ext_reset_n_i(ext_rst_n),
    .rtc_alarm_i(rtc), .irq_pending_i(irq), .ring_osc_en_o(ring_osc_en_o),
    .hf_osc_en_o(hf_osc_en_o), .sys_tick_o(sys_tick_o), .core_hold_o(core_hold_o),
    .stopped_o(stopped_o));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle; request held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h0, q);
  endtask : rd

  // Skips two system ticks so a pending ratio change has landed
  task automatic gap(output logic [31:0] g);
    g = 32'h0;
    repeat (2) begin
      do @(posedge clk_i); while (sys_tick_o !== 1'b1);
    end
    do begin
      @(posedge clk_i);
      g = g + 1;
    end while (sys_tick_o !== 1'b1);
  endtask : gap

  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    rd(CTRL_OFS, q);
    check(q, 32'h0);
    wr(CTRL_OFS, 8'h01);
    rd(STATUS_OFS, q);
    check(q, 32'h0);
    repeat (60) @(posedge clk_i);
    rd(STATUS_OFS, q);
    check(q, 32'h9);
    sel <= 4'h0;
    wr(CTRL_OFS, 8'h02);
    sel <= 4'hf;
    wr(8'h0c, 8'hff);
    rd(CTRL_OFS, q);
    check(q, 32'h1);
    rd(8'h0c, q);
    check(q, 32'h0);
  endtask : t_reset

  task automatic t_clocking();
    logic [31:0] g;
    // Codes 5 to 7 fall back to the ring oscillator
    for (int s = 0; s < 8; s++) begin
      wr(CTRL_OFS, 8'(s));
      gap(g);
      check(g, 32'(PER[s < 5 ? s : 0]));
    end
    for (int c = 1; c < 4; c++) begin
      wr(CTRL_OFS, 8'(c << CTRL_CD_LSB));
      gap(g);
      check(g, 32'(PER[0] << c));
    end
  endtask : t_clocking

  task automatic t_modes();
    logic [31:0] g;
    logic [31:0] q;
    wr(CTRL_OFS, 8'h20);
    gap(g);
    check(g, 32'(PER[0] * 256));
    rd(STATUS_OFS, q);
    check(q, 32'h28);
    for (int s = 3; s < 5; s++) begin
      wr(CTRL_OFS, 8'(8'h38 + (s - 3) * 4));
      gap(g);
      check(g, 32'(PER[s]));
      rd(STATUS_OFS, q);
      check(q, 32'(8'h48 + s));
    end
    // Switchback from each power mode, pending interrupt held two cycles
    for (int i = 0; i < 2; i++) begin
      wr(CTRL_OFS, 8'(8'h60 + i * 8'h18));
      irq <= 1'b1;
      repeat (2) @(posedge clk_i);
      irq <= 1'b0;
      rd(CTRL_OFS, q);
      check(q, 32'(8'h40 + i * 8'h18));
      gap(g);
      check(g, 32'(PER[0] << (3 * i)));
    end
  endtask : t_modes

  task automatic t_stop();
    logic [31:0] q;
    int k;
    for (int w = 0; w < 3; w++) begin
      wr(CTRL_OFS, w == 1 ? 8'h81 : 8'h01);
      wr(STOP_OFS, 8'h01);
      check(32'({stopped_o, ring_osc_en_o, hf_osc_en_o}), 32'h4);
      rd(STOP_OFS, q);
      check(q, 32'h1);
      rd(STATUS_OFS, q);
      check(q, 32'h10);
      k = 0;
      repeat (16) begin
        @(posedge clk_i);
        if (sys_tick_o !== 1'b0) k++;
      end
      check(32'(k), 32'h0);
      if (w == 0) ext_int <= 1'b1;
      if (w == 1) ext_rst_n <= 1'b0;
      if (w == 2) rtc <= 1'b1;
      @(posedge clk_i);
      ext_int <= 1'b0;
      ext_rst_n <= 1'b1;
      rtc <= 1'b0;
      @(posedge clk_i);
      check(32'(stopped_o), 32'h0);
      rd(STATUS_OFS, q);
      check(q, w == 1 ? 32'h0 : 32'h80);
      k = 0;
      while (core_hold_o !== 1'b0) begin
        @(posedge clk_i);
        k++;
      end
      check(32'(w == 1 ? k < 3 : k > 40 && k < 60), 32'h1);
      rd(STATUS_OFS, q);
      check(q, w == 1 ? 32'h0 : 32'h9);
    end
  endtask : t_stop

  initial begin
    repeat (4) @(posedge clk_i);
    check(32'({ring_osc_en_o, hf_osc_en_o, core_hold_o, sys_tick_o}), 32'he);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_clocking();
    t_modes();
    t_stop();
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule : tb_sys_clock_pm
